// >>> dv/ctc_pin_src.sv
// Drives the count and trigger pins the way an outside source would
module ctc_pin_src (
    input wire logic sys_clk,
    output logic count_input_pin,
    output logic capture_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD_CLKS = 24;

    // Both pins idle high
    initial begin
        count_input_pin = 1'b1;
        capture_trigger_pin = 1'b1;
    end

    // One level, held two machine cycles
    task automatic drive(input logic trig, input logic lvl);
        @(posedge sys_clk);
        if (trig) begin
            capture_trigger_pin <= lvl;
        end else begin
            count_input_pin <= lvl;
        end
        repeat (HOLD_CLKS - 1) @(posedge sys_clk);
    endtask : drive

    // A number of high-low-high pulses on one pin
    task automatic pulse(input logic trig, input int n);
        repeat (n) begin
            drive(trig, 1'b0);
            drive(trig, 1'b1);
        end
    endtask : pulse
endmodule : ctc_pin_src

// >>> dv/test_ctc_timer.sv
`include "ctc_map.svh"

module test_ctc_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import ctc_pkg::*;
    logic sys_clk;
    logic reset;
    ctc_req_s req;
    logic count_input_pin;
    logic capture_trigger_pin;
    logic [7:0] rd_data;
    logic irq;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    // Block under test and the pin source
    ctc_timer #(.CNT_W(16)) ctc_timer_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .bus_req(req),
        .count_input_pin(count_input_pin),
        .capture_trigger_pin(capture_trigger_pin),
        .rd_data(rd_data),
        .irq(irq)
    );
    ctc_pin_src ctc_pin_src_inst (
        .sys_clk(sys_clk),
        .count_input_pin(count_input_pin),
        .capture_trigger_pin(capture_trigger_pin)
    );

    // Free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] q);
        compares++;
        if (q !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, q);
        end
    endtask : chk

    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 q = rd_data;
    endtask : rd

    task automatic set16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 4'h1, d[15:8]);
    endtask : set16

    task automatic chk8(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask : chk8

    task automatic chk16(input string nm, input logic [3:0] a,
                         input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + 4'h1, hi);
        chk(nm, e, {hi, lo});
    endtask : chk16

    task automatic chk_irq(input logic e);
        chk("irq", {15'h0000, e}, {15'h0000, irq});
    endtask : chk_irq

    // Runs with a control value for exactly n clocks, then stops
    task automatic run_for(input logic [7:0] c, input int n);
        wr(4'h0, c);
        repeat (n - 2) @(posedge sys_clk);
        wr(4'h0, 8'h00);
    endtask : run_for

    task automatic t_reset();
        chk8("ctrl", 4'h0, 8'h00);
        chk16("count", 4'h1, 16'h0000);
        chk16("capture", 4'h3, 16'h0000);
        chk8("status", 4'h5, 8'h00);
        chk8("mask", 4'h6, `CTC_MASK_RST);
        chk8("unmapped", 4'h7, 8'h00);
        wr(4'h0, 8'hff);
        chk8("ctrl used", 4'h0, `CTC_CTRL_USED);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h30);
        chk8("ctrl reserved", 4'h0, 8'h00);
    endtask : t_reset

    task automatic t_timer();
        set16(4'h1, 16'h0000);
        run_for(8'h04, 60);
        chk16("timer count", 4'h1, 16'h0005);
        set16(4'h1, 16'h0000);
        run_for(8'h84, 24);
        chk16("baud count", 4'h1, 16'h000c);
        chk8("status", 4'h5, 8'h00);
    endtask : t_timer

    task automatic t_ovf();
        set16(4'h3, 16'h1234);
        set16(4'h1, 16'hffff);
        run_for(8'h04, 12);
        chk16("reload", 4'h1, 16'h1234);
        chk8("ovf flag", 4'h5, 8'h01);
        chk_irq(1'b1);
        chk8("sticky", 4'h5, 8'h01);
        wr(4'h5, 8'h01);
        chk8("cleared", 4'h5, 8'h00);
        chk_irq(1'b0);
        wr(4'h6, 8'h00);
        set16(4'h1, 16'hffff);
        run_for(8'h05, 12);
        chk16("wrap", 4'h1, 16'h0000);
        chk8("cap ovf", 4'h5, 8'h01);
        chk_irq(1'b0);
        wr(4'h6, 8'h03);
        chk8("unmasked", 4'h5, 8'h01);
        chk_irq(1'b1);
        wr(4'h5, 8'h01);
        set16(4'h1, 16'hffff);
        run_for(8'h44, 12);
        chk16("baud roll", 4'h1, 16'h1239);
        chk8("no flag", 4'h5, 8'h00);
    endtask : t_ovf

    task automatic t_count();
        set16(4'h1, 16'h0000);
        wr(4'h0, 8'h06);
        ctc_pin_src_inst.pulse(1'b0, 5);
        repeat (12) @(posedge sys_clk);
        wr(4'h0, 8'hc3);
        chk16("events", 4'h1, 16'h0005);
        ctc_pin_src_inst.pulse(1'b0, 2);
        chk16("stopped", 4'h1, 16'h0005);
        chk8("stop flags", 4'h5, 8'h00);
    endtask : t_count

    task automatic t_capture();
        set16(4'h1, 16'h0abc);
        set16(4'h3, 16'h0000);
        wr(4'h0, 8'h0f);
        ctc_pin_src_inst.pulse(1'b1, 1);
        chk16("capture", 4'h3, 16'h0abc);
        chk16("count kept", 4'h1, 16'h0abc);
        chk8("ext flag", 4'h5, 8'h02);
        chk_irq(1'b1);
        wr(4'h5, 8'h02);
        set16(4'h1, 16'h0def);
        wr(4'h0, 8'h07);
        ctc_pin_src_inst.pulse(1'b1, 1);
        chk16("no capture", 4'h3, 16'h0abc);
        chk8("no ext", 4'h5, 8'h00);
        set16(4'h3, 16'h5a5a);
        wr(4'h0, 8'h0e);
        ctc_pin_src_inst.pulse(1'b1, 1);
        chk16("trig reload", 4'h1, 16'h5a5a);
        chk8("reload ext", 4'h5, 8'h02);
        wr(4'h5, 8'h02);
        set16(4'h1, 16'h0011);
        wr(4'h0, 8'h4e);
        ctc_pin_src_inst.pulse(1'b1, 1);
        chk16("baud trig", 4'h1, 16'h0011);
        chk8("baud ext", 4'h5, 8'h02);
        wr(4'h0, 8'h00);
    endtask : t_capture

    // Main sequence
    initial begin
        reset = 1'b1;
        req = '0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_timer();
        t_ovf();
        t_count();
        t_capture();
        results();
    end
endmodule : test_ctc_timer

// >>> hdl/ctc_phase_gen.sv
`include "ctc_map.svh"

module ctc_phase_gen #(
    parameter int MC_CLKS = `CTC_MC_CLKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    output logic sample_stb,
    output logic update_stb,
    output logic state_stb
);
    import ctc_pkg::*;

    logic [3:0] idx_r;

    // Phase logic assumes six states of two phases each
    if (MC_CLKS != 12) begin : g_chk
        $error("ctc_phase_gen: MC_CLKS must be 12");
    end

    // Oscillator period index within the machine cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            idx_r <= 4'h0;
        end else if (idx_r == `CTC_LAST_IDX) begin
            idx_r <= 4'h0;
        end else begin
            idx_r <= idx_r + 4'h1;
        end
    end

    // Phase strobes: sampling, count update, every state time
    assign sample_stb = (idx_r == `CTC_SAMPLE_IDX);
    assign update_stb = (idx_r == `CTC_UPDATE_IDX);
    assign state_stb = ~idx_r[0];

endmodule : ctc_phase_gen

// >>> hdl/ctc_timer.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`include "ctc_map.svh"

module ctc_timer #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input ctc_pkg::ctc_req_s bus_req,
    input wire logic count_input_pin,
    input wire logic capture_trigger_pin,
    output logic [7:0] rd_data,
    output logic irq
);
    import ctc_pkg::*;

    logic [7:0] timer_control_reg_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] cap_r;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] rd_data_r;
    logic irq_r;
    logic [1:0] pins;
    logic [1:0] smp_r;
    logic [1:0] pend_r;
    logic sample_stb;
    logic update_stb;
    logic state_stb;
    logic run_control;
    logic counter_select;
    logic external_trigger_enable;
    ctc_mode_e mode;
    logic cnt_ev;
    logic tmr_ev;
    logic inc_ev;
    logic ovf_ev;
    logic ext_ev;
    logic cap_ev;
    logic [7:0] st_set;
    logic [7:0] st_clr;

    // The byte split of the count is fixed at two bytes
    if (CNT_W != 16) begin : g_chk
        $error("ctc_timer: CNT_W must be 16");
    end

    // Mode from run, baud selects and capture/reload select
    function automatic ctc_mode_e decode_mode(input logic [7:0] c);
        if (!c[`CTC_CTRL_RUN_BIT]) begin
            decode_mode = CTC_MODE_OFF;
        end else if (c[`CTC_CTRL_RXB_BIT] || c[`CTC_CTRL_TXB_BIT]) begin
            decode_mode = CTC_MODE_BAUD;
        end else if (c[`CTC_CTRL_CRS_BIT]) begin
            decode_mode = CTC_MODE_CAPTURE;
        end else begin
            decode_mode = CTC_MODE_RELOAD;
        end
    endfunction : decode_mode

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input ctc_req_s r, input logic [3:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction : wr_hit

    ctc_phase_gen #(
        .MC_CLKS(`CTC_MC_CLKS)
    ) u_phase (
        .sys_clk(sys_clk),
        .reset(reset),
        .sample_stb(sample_stb),
        .update_stb(update_stb),
        .state_stb(state_stb)
    );

    // Control fields
    assign run_control = timer_control_reg_r[`CTC_CTRL_RUN_BIT];
    assign counter_select = timer_control_reg_r[`CTC_CTRL_CS_BIT];
    assign external_trigger_enable = timer_control_reg_r[`CTC_CTRL_EXEN_BIT];
    assign mode = decode_mode(timer_control_reg_r);
    assign pins = {capture_trigger_pin, count_input_pin};

    // Falling-edge detectors for the count pin and the trigger pin
    for (genvar i = 0; i < 2; i++) begin : g_edge
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                smp_r[i] <= 1'b0;
                pend_r[i] <= 1'b0;
            end else begin
                if (sample_stb) begin
                    smp_r[i] <= pins[i];
                end
                if (sample_stb && smp_r[i] && !pins[i]) begin
                    pend_r[i] <= 1'b1;
                end else if (update_stb) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Count events: external edges, machine cycles or state times
    assign cnt_ev = counter_select && update_stb && pend_r[0];
    assign tmr_ev = !counter_select &&
        ((mode == CTC_MODE_BAUD) ? state_stb : update_stb);
    assign inc_ev = (mode != CTC_MODE_OFF) && (cnt_ev || tmr_ev);
    assign ovf_ev = inc_ev && (count_r == {CNT_W{1'b1}});
    assign ext_ev = (mode != CTC_MODE_OFF) && external_trigger_enable &&
        update_stb && pend_r[1];
    assign cap_ev = ext_ev && (mode == CTC_MODE_CAPTURE);

    // Next count: software write, then reload, then increment
    always_comb begin
        count_nxt = count_r;
        if (ext_ev && (mode == CTC_MODE_RELOAD)) begin
            count_nxt = cap_r;
        end else if (ovf_ev && (mode != CTC_MODE_CAPTURE)) begin
            count_nxt = cap_r;
        end else if (inc_ev) begin
            count_nxt = count_r + 16'h0001;
        end
        if (wr_hit(bus_req, `CTC_OFS_CNT_LO)) begin
            count_nxt[7:0] = bus_req.wdata;
        end
        if (wr_hit(bus_req, `CTC_OFS_CNT_HI)) begin
            count_nxt[15:8] = bus_req.wdata;
        end
    end

    // Count bytes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_r <= `CTC_CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Capture bytes; a capture event wins over a software write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cap_r <= `CTC_CAP_RST;
        end else if (cap_ev) begin
            cap_r <= count_r;
        end else begin
            if (wr_hit(bus_req, `CTC_OFS_CAP_LO)) begin
                cap_r[7:0] <= bus_req.wdata;
            end
            if (wr_hit(bus_req, `CTC_OFS_CAP_HI)) begin
                cap_r[15:8] <= bus_req.wdata;
            end
        end
    end

    // Control register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_control_reg_r <= `CTC_CTRL_RST;
        end else if (wr_hit(bus_req, `CTC_OFS_CTRL)) begin
            timer_control_reg_r <= bus_req.wdata & `CTC_CTRL_USED;
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    always_comb begin
        st_set = 8'h00;
        st_set[`CTC_ST_OVF_BIT] = ovf_ev && (mode != CTC_MODE_BAUD);
        st_set[`CTC_ST_EXT_BIT] = ext_ev;
        st_clr = wr_hit(bus_req, `CTC_OFS_STATUS) ? bus_req.wdata : 8'h00;
        status_nxt = ((status_r & ~st_clr) | st_set) & `CTC_ST_USED;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_r <= `CTC_STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Interrupt mask; next value also feeds the interrupt line
    always_comb begin
        mask_nxt = mask_r;
        if (wr_hit(bus_req, `CTC_OFS_MASK)) begin
            mask_nxt = bus_req.wdata & `CTC_ST_USED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_r <= `CTC_MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // One interrupt line; mask and flag changes show in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_nxt & mask_nxt);
        end
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (reset || !bus_req.rd) begin
            rd_data_r <= 8'h00;
        end else begin
            case (bus_req.addr)
                `CTC_OFS_CTRL: rd_data_r <= timer_control_reg_r;
                `CTC_OFS_CNT_LO: rd_data_r <= count_r[7:0];
                `CTC_OFS_CNT_HI: rd_data_r <= count_r[15:8];
                `CTC_OFS_CAP_LO: rd_data_r <= cap_r[7:0];
                `CTC_OFS_CAP_HI: rd_data_r <= cap_r[15:8];
                `CTC_OFS_STATUS: rd_data_r <= status_r;
                `CTC_OFS_MASK: rd_data_r <= mask_r;
                default: rd_data_r <= 8'h00;
            endcase
        end
    end

    assign rd_data = rd_data_r;
    assign irq = irq_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // A software write touches the count in this cycle
    logic cnt_wr;
    assign cnt_wr = wr_hit(bus_req, `CTC_OFS_CNT_LO) ||
        wr_hit(bus_req, `CTC_OFS_CNT_HI);

    sequence fall_seen;
        sample_stb && smp_r[0] && !count_input_pin;
    endsequence

    sequence update_after_fall;
        ##[1:12] update_stb;
    endsequence

    timer_rate_a: assert property (
        (mode == CTC_MODE_RELOAD) && !counter_select && update_stb &&
        !cnt_wr && !ext_ev && (count_r != 16'hffff) |=>
        (count_r == $past(count_r) + 16'h0001))
        else $error("timer did not step at the machine cycle");

    timer_idle_a: assert property (
        (mode == CTC_MODE_RELOAD) && !counter_select && !update_stb &&
        !cnt_wr && !ext_ev |=> $stable(count_r))
        else $error("timer stepped outside the machine cycle");

    edge_catch_a: assert property (
        fall_seen |=> pend_r[0])
        else $error("falling edge on count pin not caught");

    edge_update_a: assert property (
        fall_seen ##7 (update_stb && counter_select &&
        (mode != CTC_MODE_OFF) && !ext_ev && !cnt_wr &&
        (count_r != 16'hffff)) |=>
        (count_r == $past(count_r) + 16'h0001))
        else $error("counted edge not shown at update phase");

    edge_span_a: assert property (
        fall_seen |-> update_after_fall)
        else $error("no update phase after a caught edge");

    edge_rate_a: assert property (
        cnt_ev |=> (!cnt_ev)[*8])
        else $error("events counted faster than every machine cycle");

    stop_hold_a: assert property (
        !run_control && !cnt_wr |=> $stable(count_r) &&
        (!status_r[`CTC_ST_OVF_BIT] || $past(status_r[`CTC_ST_OVF_BIT])))
        else $error("stopped timer changed count or flags");

    mode_decode_a: assert property (
        run_control && !timer_control_reg_r[`CTC_CTRL_RXB_BIT] &&
        !timer_control_reg_r[`CTC_CTRL_TXB_BIT] |->
        (mode == (timer_control_reg_r[`CTC_CTRL_CRS_BIT] ?
        CTC_MODE_CAPTURE : CTC_MODE_RELOAD)))
        else $error("wrong mode for running timer");

    ovf_flag_a: assert property (
        ovf_ev && (mode == CTC_MODE_CAPTURE) && !cnt_wr |=>
        status_r[`CTC_ST_OVF_BIT] && (count_r == 16'h0000))
        else $error("capture overflow did not wrap and flag");

    capture_copy_a: assert property (
        cap_ev |=> (cap_r == $past(count_r)) && status_r[`CTC_ST_EXT_BIT])
        else $error("capture edge did not copy count and flag");

    reload_a: assert property (
        ovf_ev && (mode == CTC_MODE_RELOAD) && !cnt_wr |=>
        (count_r == $past(cap_r)) && status_r[`CTC_ST_OVF_BIT])
        else $error("reload overflow did not reload and flag");

    baud_roll_a: assert property (
        ovf_ev && (mode == CTC_MODE_BAUD) && !cnt_wr &&
        !status_r[`CTC_ST_OVF_BIT] |=>
        (count_r == $past(cap_r)) && !status_r[`CTC_ST_OVF_BIT])
        else $error("baud rollover wrong reload or flag");

    irq_or_a: assert property (
        irq_r == ((status_r & mask_r) != 8'h00))
        else $error("interrupt line differs from unmasked flags");

endmodule : ctc_timer

// >>> inc/ctc_map.svh
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

// Register offsets on the plain register port
`define CTC_OFS_CTRL 4'h0
`define CTC_OFS_CNT_LO 4'h1
`define CTC_OFS_CNT_HI 4'h2
`define CTC_OFS_CAP_LO 4'h3
`define CTC_OFS_CAP_HI 4'h4
`define CTC_OFS_STATUS 4'h5
`define CTC_OFS_MASK 4'h6

// Control register field positions
`define CTC_CTRL_CRS_BIT 0
`define CTC_CTRL_CS_BIT 1
`define CTC_CTRL_RUN_BIT 2
`define CTC_CTRL_EXEN_BIT 3
`define CTC_CTRL_TXB_BIT 6
`define CTC_CTRL_RXB_BIT 7
`define CTC_CTRL_USED 8'hcf

// Status and mask field positions
`define CTC_ST_OVF_BIT 0
`define CTC_ST_EXT_BIT 1
`define CTC_ST_USED 8'h03

// Reset values
`define CTC_CTRL_RST 8'h00
`define CTC_CNT_RST 16'h0000
`define CTC_CAP_RST 16'h0000
`define CTC_STATUS_RST 8'h00
`define CTC_MASK_RST 8'h03

// Machine-cycle timing in oscillator periods
`define CTC_MC_CLKS 12
`define CTC_EDGE_CLKS 24
`define CTC_UPDATE_IDX 4'h4
`define CTC_SAMPLE_IDX 4'h9
`define CTC_LAST_IDX 4'hb

`endif

// >>> inc/ctc_pkg.sv
package ctc_pkg;

    // Operating modes of the timer
    typedef enum logic [1:0] {
        CTC_MODE_OFF,
        CTC_MODE_RELOAD,
        CTC_MODE_CAPTURE,
        CTC_MODE_BAUD
    } ctc_mode_e;

    // One register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ctc_req_s;

endpackage : ctc_pkg
